// file: logic/ccu_clock_control.sv
// Module: clock control unit with mode, control, flag and PLL registers
//
// Notes on behaviour
// - Oscillator input optionally halved to form the PLL reference.
// - PLL multiplies reference by six, eight, ten or fourteen.
// - Multiplied clock divided by one to seven for PLL system source.
// - Undivided PLL clock exported for high-speed peripherals.
// - With PLL off, system clock may be reference divided by sixteen.
// - Auxiliary source during low-power wait gets automatic divide by sixteen.
// - Selected system clock goes to all peripherals and core prescaler.
// - Core clock slowed up to eight times; peripherals keep system clock.
// - Stop and halt freeze the main oscillator and mask the auxiliary clock.
// - Halt entered only by halt instruction, left only by reset.
// - Stop entry and exit come from the wake-up interrupt unit.
// - Hardware, software and watchdog resets each leave a cause flag.
// - Mode register holds input halving and core prescale factor.
// - Control register holds low-power settings and halt interpretation.
// - Flag register mixes status flags and source select bits.
// - PLL register holds multiply and post-divide selections.
// - Post-divide field all ones or low-power wait switches PLL off, otherwise on.
// - Prescale zero leaves core clock as system clock, else divide value+1.
// - Wait without low-power enable stops only the core clock.
//
// All clocks are modelled as enables on the single 20 MHz clock: each *_tick
// output is a one-cycle pulse marking one edge of the derived clock.
`timescale 1ns/1ps
`default_nettype none

module ccu_clock_control
  import ccu_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic osc_input_clock,
  input wire logic auxiliary_clock,
  input wire logic aux_present,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic wait_for_interrupt,
  input wire logic halt_instr,
  input wire logic stop_request,
  input wire logic wake_event,
  input wire logic soft_reset_evt,
  input wire logic wdog_reset_evt,
  input wire logic hard_reset_evt,
  output logic pll_reference_clock,
  output logic pll_fast_tick,
  output logic system_clock,
  output logic core_clock,
  output logic osc_enable,
  output logic halted,
  output logic stopped
);

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [7:0] mode_register_r;
  logic [7:0] clock_control_reg_r;
  logic [7:0] flag_ctl_r;
  logic [7:0] pll_config_reg_r;
  logic [2:0] cause_r;
  logic halt_r;
  logic stop_r;
  logic wfi_r;
  logic [7:0] lock_cnt_r;
  logic ref_ph_r;
  logic osc_d_r;
  logic [3:0] mul_ph_r;
  logic osc_rise;
  logic pll_on;
  logic pll_locked;
  logic frozen;
  logic lp_wait;
  logic [2:0] post_div_select;
  logic [2:0] core_prescale_field;
  logic low_power_wait_enable;
  ccu_src_t src_sel;
  logic src_tick;
  logic sys_tick;
  logic core_tick;
  logic [3:0] sys_div_last;
  logic [3:0] mul_last;

  assign post_div_select = pll_config_reg_r[CCU_PLL_DX_LSB +: 3];
  assign core_prescale_field = mode_register_r[CCU_MODE_PRS_LSB +: 3];
  assign low_power_wait_enable = clock_control_reg_r[CCU_CTL_LPWFI_BIT];

  // Maps the multiply select code to the last fast-clock phase (ticks minus one) per reference edge
  function automatic logic [3:0] mul_to_last(input logic [1:0] mx);
    unique case (mx)
      2'b00: mul_to_last = 4'h9;
      2'b01: mul_to_last = 4'h5;
      2'b10: mul_to_last = 4'hd;
      2'b11: mul_to_last = 4'h7;
    endcase
  endfunction

  // ==========================================================================
  // Register writes
  // ==========================================================================
  // Mode register: input halving and core prescale
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_register_r <= CCU_MODE_RST;
    end else if (reg_wr && reg_addr == CCU_OFS_MODE) begin
      mode_register_r <= reg_wdata;
    end
  end

  // Control register: low-power wait and halt interpretation
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      clock_control_reg_r <= CCU_CTL_RST;
    end else if (reg_wr && reg_addr == CCU_OFS_CTL) begin
      clock_control_reg_r <= reg_wdata;
    end
  end

  // Flag register control bits; auxiliary select needs the clock actually present
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag_ctl_r <= CCU_FLAG_CTL_RST;
    end else if (reg_wr && reg_addr == CCU_OFS_FLAG) begin
      flag_ctl_r[CCU_FLAG_PLLSEL_BIT] <= reg_wdata[CCU_FLAG_PLLSEL_BIT];
      flag_ctl_r[CCU_FLAG_XTDIV16_BIT] <= reg_wdata[CCU_FLAG_XTDIV16_BIT];
      flag_ctl_r[CCU_FLAG_AUXSEL_BIT] <= reg_wdata[CCU_FLAG_AUXSEL_BIT] && aux_present;
    end else if (!aux_present) begin
      flag_ctl_r[CCU_FLAG_AUXSEL_BIT] <= 1'b0; // Never stay on a dead clock
    end
  end

  // PLL configuration register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pll_config_reg_r <= CCU_PLL_RST;
    end else if (reg_wr && reg_addr == CCU_OFS_PLL) begin
      pll_config_reg_r <= reg_wdata;
    end
  end

  // ==========================================================================
  // Reset cause flags
  // ==========================================================================
  // Set wins over a software clear in the same cycle; writing one clears
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cause_r <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == CCU_OFS_FLAG) begin
        cause_r <= cause_r & ~reg_wdata[CCU_FLAG_HARD_BIT -: 3];
      end
      if (hard_reset_evt) cause_r[2] <= 1'b1;
      if (soft_reset_evt) cause_r[1] <= 1'b1;
      if (wdog_reset_evt) cause_r[0] <= 1'b1;
    end
  end

  // ==========================================================================
  // Power modes
  // ==========================================================================
  // Halt is left only through reset, so no clear path exists here
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      halt_r <= 1'b0;
    end else if (halt_instr && clock_control_reg_r[CCU_CTL_HALT_BIT]) begin
      halt_r <= 1'b1;
    end
  end

  // Stop is driven entirely by the wake-up unit's request and wake lines
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stop_r <= 1'b0;
    end else if (wake_event) begin
      stop_r <= 1'b0;
    end else if (stop_request) begin
      stop_r <= 1'b1;
    end
  end

  // Wait state: held from the instruction until an interrupt wakes the core
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wfi_r <= 1'b0;
    end else if (wake_event) begin
      wfi_r <= 1'b0;
    end else if (wait_for_interrupt) begin
      wfi_r <= 1'b1;
    end
  end

  assign frozen = halt_r || stop_r;
  assign lp_wait = wfi_r && low_power_wait_enable;
  assign osc_enable = !frozen;
  assign halted = halt_r;
  assign stopped = stop_r;

  // ==========================================================================
  // Reference clock and PLL model
  // ==========================================================================
  // Oscillator edge detect; freezing the oscillator stops every derived tick
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_d_r <= 1'b1; // Taken as high so a level held through reset is no edge
      ref_ph_r <= 1'b0;
    end else begin
      osc_d_r <= osc_input_clock;
      if (osc_rise) begin
        ref_ph_r <= !ref_ph_r;
      end
    end
  end

  assign osc_rise = osc_input_clock && !osc_d_r && !frozen;
  // Halving takes every other oscillator edge
  assign pll_reference_clock = osc_rise &&
                               (!mode_register_r[CCU_MODE_DIV2_BIT] || ref_ph_r);

  // PLL off in low-power wait or with the post-divider field all ones
  assign pll_on = (post_div_select != CCU_DX_OFF) && !lp_wait;

  // Lock counter restarts whenever the PLL is switched off
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lock_cnt_r <= 8'h0_000;
    end else if (!pll_on) begin
      lock_cnt_r <= 8'h0_000;
    end else if (pll_reference_clock && lock_cnt_r != CCU_LOCK_CYCLES) begin
      lock_cnt_r <= lock_cnt_r + 8'h0_001;
    end
  end

  assign pll_locked = lock_cnt_r == CCU_LOCK_CYCLES;

  // Fast clock: the multiplier is modelled as a phase count per reference edge
  assign mul_last = mul_to_last(pll_config_reg_r[CCU_PLL_MX_LSB +: 2]);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mul_ph_r <= 4'h0;
    end else if (!pll_on || frozen) begin
      mul_ph_r <= 4'h0;
    end else if (pll_reference_clock) begin
      mul_ph_r <= 4'h0;
    end else if (mul_ph_r <= mul_last) begin
      mul_ph_r <= mul_ph_r + 4'h1;
    end
  end

  // A limitation: output rate is capped by the modelling clock
  assign pll_fast_tick = pll_on && !frozen && (mul_ph_r <= mul_last);

  // ==========================================================================
  // Source selection
  // ==========================================================================
  // Priority: auxiliary, low-power wait or slow select, PLL when locked, reference
  always_comb begin
    if (flag_ctl_r[CCU_FLAG_AUXSEL_BIT]) begin
      src_sel = CCU_SRC_AUX;
    end else if (lp_wait || !flag_ctl_r[CCU_FLAG_XTDIV16_BIT]) begin
      src_sel = CCU_SRC_SLOW;
    end else if (flag_ctl_r[CCU_FLAG_PLLSEL_BIT] && pll_on && pll_locked) begin
      src_sel = CCU_SRC_PLL;
    end else begin
      src_sel = CCU_SRC_REF;
    end
  end

  always_comb begin
    unique case (src_sel)
      CCU_SRC_REF: begin
        src_tick = pll_reference_clock;
        sys_div_last = 4'h0;
      end
      CCU_SRC_SLOW: begin
        src_tick = pll_reference_clock;
        sys_div_last = CCU_SLOW_DIV_LAST; // Sixteen reference ticks per system tick
      end
      CCU_SRC_PLL: begin
        src_tick = pll_fast_tick;
        sys_div_last = {1'b0, post_div_select};
      end
      CCU_SRC_AUX: begin
        src_tick = auxiliary_clock && !frozen;
        sys_div_last = lp_wait ? CCU_SLOW_DIV_LAST : 4'h0;
      end
    endcase
  end

  // Divider compares against the live divisor, so a change can cut or stretch the period in progress
  ccu_glitchfree_div u_sys_div (
    .clock(clock),
    .arst_n(arst_n),
    .div_last(sys_div_last),
    .run(src_tick),
    .tick(sys_tick)
  );

  // One system clock feeds all peripherals and the core prescaler
  assign system_clock = sys_tick;

  // ==========================================================================
  // Core clock prescaler
  // ==========================================================================
  // Zero prescale passes every system tick, so phase is preserved
  ccu_glitchfree_div u_core_div (
    .clock(clock),
    .arst_n(arst_n),
    .div_last({1'b0, core_prescale_field}),
    .run(sys_tick),
    .tick(core_tick)
  );

  // Without low-power enable, wait stops only the core clock; peripherals keep running
  assign core_clock = core_tick && !wfi_r;

  // ==========================================================================
  // Register read
  // ==========================================================================
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h0_000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        CCU_OFS_MODE: reg_rdata <= mode_register_r;
        CCU_OFS_CTL: reg_rdata <= clock_control_reg_r;
        CCU_OFS_FLAG: reg_rdata <= {cause_r, aux_present, pll_locked, flag_ctl_r[2:0]};
        CCU_OFS_PLL: reg_rdata <= pll_config_reg_r;
        default: reg_rdata <= 8'h0_000;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_halt_sticky: assert property (@(posedge clock) disable iff (!arst_n)
    halt_r |=> halt_r) else $error("halt left without reset");
  a_frozen_silent: assert property (@(posedge clock) disable iff (!arst_n)
    frozen |-> !system_clock && !core_clock && !osc_enable)
    else $error("clock ran while frozen");
  a_pll_off_code: assert property (@(posedge clock) disable iff (!arst_n)
    (post_div_select == CCU_DX_OFF) |-> !pll_fast_tick)
    else $error("PLL ran with all-ones divider");
  a_core_no_div: assert property (@(posedge clock) disable iff (!arst_n)
    (core_prescale_field == 3'h0 && !wfi_r && $stable(core_prescale_field))
      |-> (core_clock == system_clock)) else $error("core clock not equal to system");
  a_wait_core_stop: assert property (@(posedge clock) disable iff (!arst_n)
    wfi_r |-> !core_clock) else $error("core clock ran in wait");
  a_hard_cause: assert property (@(posedge clock) disable iff (!arst_n)
    hard_reset_evt |=> cause_r[2]) else $error("hardware reset flag lost");
  a_wdog_cause: assert property (@(posedge clock) disable iff (!arst_n)
    wdog_reset_evt |=> cause_r[0]) else $error("watchdog reset flag lost");
  a_stop_wake: assert property (@(posedge clock) disable iff (!arst_n)
    wake_event |=> !stop_r) else $error("stop not left on wake");
  a_aux_lp_div: assert property (@(posedge clock) disable iff (!arst_n)
    (src_sel == CCU_SRC_AUX && lp_wait) |-> sys_div_last == CCU_SLOW_DIV_LAST)
    else $error("aux not divided in low-power wait");
  a_ref_halved: assert property (@(posedge clock) disable iff (!arst_n)
    (pll_reference_clock && mode_register_r[CCU_MODE_DIV2_BIT]) |-> ref_ph_r)
    else $error("reference not halved");

endmodule // ccu_clock_control

`default_nettype wire

// file: logic/ccu_glitchfree_div.sv
// Module: pulse-swallowing clock divider producing a clock enable without glitches
`timescale 1ns/1ps
`default_nettype none

module ccu_glitchfree_div (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] div_last,
  input wire logic run,
  output logic tick
);

  logic [3:0] count_r;

  // ==========================================================================
  // Counter
  // ==========================================================================
  // Divisor changes act at once, so a lowered divisor can truncate the period in progress
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= 4'h0;
    end else if (run) begin
      if (count_r >= div_last) begin
        count_r <= 4'h0;
      end else begin
        count_r <= count_r + 4'h1;
      end
    end
  end

  // Enable pulse on the last count of each period
  assign tick = run && (count_r >= div_last);

endmodule // ccu_glitchfree_div

`default_nettype wire

// file: logic/ccu_pkg.sv
// Package: register map, field positions and reset values of the clock control unit
package ccu_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] CCU_OFS_MODE = 8'h0_0eb;
  localparam logic [7:0] CCU_OFS_CTL = 8'h0_0f0;
  localparam logic [7:0] CCU_OFS_FLAG = 8'h0_0f2;
  localparam logic [7:0] CCU_OFS_PLL = 8'h0_0f6;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  // Mode register: core prescale in [2:0], input halving in bit 5
  localparam int CCU_MODE_PRS_LSB = 0;
  localparam int CCU_MODE_DIV2_BIT = 5;
  // Control register
  localparam int CCU_CTL_LPWFI_BIT = 0;
  localparam int CCU_CTL_HALT_BIT = 3;
  // Flag register
  localparam int CCU_FLAG_PLLSEL_BIT = 0;
  localparam int CCU_FLAG_XTDIV16_BIT = 1;
  localparam int CCU_FLAG_AUXSEL_BIT = 2;
  localparam int CCU_FLAG_AUXST_BIT = 4;
  localparam int CCU_FLAG_WDG_BIT = 5;
  localparam int CCU_FLAG_SOFT_BIT = 6;
  localparam int CCU_FLAG_HARD_BIT = 7;
  localparam int CCU_FLAG_LOCK_BIT = 3;
  // PLL configuration: multiply select [1:0], post divide select [6:4]
  localparam int CCU_PLL_MX_LSB = 0;
  localparam int CCU_PLL_DX_LSB = 4;

  // ==========================================================================
  // Reset values and constants
  // ==========================================================================
  localparam logic [7:0] CCU_MODE_RST = 8'h0_020;
  localparam logic [7:0] CCU_CTL_RST = 8'h0_000;
  localparam logic [7:0] CCU_FLAG_CTL_RST = 8'h0_002;
  localparam logic [7:0] CCU_PLL_RST = 8'h0_070;
  localparam logic [2:0] CCU_DX_OFF = 3'h7;
  localparam logic [3:0] CCU_SLOW_DIV_LAST = 4'hf;
  // PLL lock is modelled as a settle count in reference cycles
  localparam logic [7:0] CCU_LOCK_CYCLES = 8'h0_040;

  // Clock source selection
  typedef enum logic [1:0] {CCU_SRC_REF, CCU_SRC_SLOW, CCU_SRC_PLL, CCU_SRC_AUX} ccu_src_t;

endpackage : ccu_pkg

// file: test/ccu_clock_control_tb.sv
// Testbench: clock control unit driven through its registers and power events
`timescale 1ns/1ps
`default_nettype none

module ccu_clock_control_tb;
  import ccu_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [6:0] evt = 7'h00;
  logic aux_on = 1'b0;
  logic [7:0] reg_rdata;
  logic osc_input_clock, auxiliary_clock, aux_present, pll_reference_clock, pll_fast_tick;
  logic system_clock, core_clock, osc_enable, halted, stopped, osc_q, count_on = 1'b0;
  logic [15:0] rd;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_sys, n_core, n_ref, n_fast, n_aux, n_osc;

  initial forever #25 clock = ~clock;

  ccu_osc_model u_osc (.clock(clock), .osc_enable(osc_enable), .aux_on(aux_on),
    .osc_input_clock(osc_input_clock), .auxiliary_clock(auxiliary_clock),
    .aux_present(aux_present));

  ccu_clock_control u_dut (.clock(clock), .arst_n(arst_n),
    .osc_input_clock(osc_input_clock), .auxiliary_clock(auxiliary_clock),
    .aux_present(aux_present), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .wait_for_interrupt(evt[0]),
    .halt_instr(evt[1]), .stop_request(evt[2]), .wake_event(evt[3]),
    .soft_reset_evt(evt[4]), .wdog_reset_evt(evt[5]), .hard_reset_evt(evt[6]),
    .pll_reference_clock(pll_reference_clock), .pll_fast_tick(pll_fast_tick),
    .system_clock(system_clock), .core_clock(core_clock), .osc_enable(osc_enable),
    .halted(halted), .stopped(stopped));

  // ==========================================================================
  // Tick counters over a measuring window
  // ==========================================================================
  always @(posedge clock) begin
    osc_q <= osc_input_clock;
    if (count_on) begin
      n_sys <= n_sys + (system_clock === 1'b1);
      n_core <= n_core + (core_clock === 1'b1);
      n_ref <= n_ref + (pll_reference_clock === 1'b1);
      n_fast <= n_fast + (pll_fast_tick === 1'b1);
      n_aux <= n_aux + (auxiliary_clock === 1'b1);
      n_osc <= n_osc + (osc_input_clock === 1'b1 && osc_q === 1'b0);
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Window edges may cut one tick either way, so counts get a small slack
  task automatic cnt(input string what, input int seen, input int exp);
    check(what, (seen - exp <= 2 && exp - seen <= 2) ? exp[15:0] : seen[15:0], exp[15:0]);
  endtask
  task automatic window(input int n);
    {n_sys, n_core, n_ref, n_fast, n_aux, n_osc} = '0;
    @(posedge clock);
    count_on <= 1'b1;
    repeat (n) @(posedge clock);
    count_on <= 1'b0;
    @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rd = {8'h00, reg_rdata};
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    evt <= 7'h01 << k;
    @(posedge clock);
    evt <= 7'h00;
    @(negedge clock);
  endtask
  task automatic do_reset();
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
  endtask
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    rdr(CCU_OFS_MODE);
    check("mode reset", rd, 16'h0020);
    rdr(CCU_OFS_CTL);
    check("control reset", rd, 16'h0000);
    rdr(CCU_OFS_FLAG);
    check("flag reset", rd & 16'h001f, 16'h0002);
    rdr(CCU_OFS_PLL);
    check("pll reset", rd, 16'h0070);
    wr(8'h55, 8'hff);
    rdr(8'h55);
    check("unmapped read", rd, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_clocks();
    window(400);
    cnt("ref halved", n_ref, n_osc / 2);
    cnt("sys default", n_sys, n_ref);
    wr(CCU_OFS_MODE, 8'h00);
    window(400);
    cnt("ref direct", n_ref, n_osc);
    cnt("sys follows ref", n_sys, n_ref);
    // Every prescale value; peripherals keep the full system clock
    for (int p = 0; p < 8; p++) begin
      wr(CCU_OFS_MODE, p[7:0]);
      window(480);
      cnt("core prescale", n_core, n_sys / (p + 1));
      cnt("sys unslowed", n_sys, n_ref);
    end
    wr(CCU_OFS_MODE, 8'h00);
    wr(CCU_OFS_FLAG, 8'h00);
    window(960);
    cnt("slow div16", n_sys, n_ref / 16);
    wr(CCU_OFS_FLAG, 8'h02);
    $display("test clocks done");
  endtask
  task automatic t_wait();
    pulse(0);
    window(200);
    check("core stopped", n_core[15:0], 16'h0000);
    cnt("sys unchanged", n_sys, n_ref);
    pulse(3);
    wr(CCU_OFS_CTL, 8'h01);
    pulse(0);
    window(960);
    cnt("lp wait div16", n_sys, n_ref / 16);
    pulse(3);
    aux_on <= 1'b1;
    wr(CCU_OFS_FLAG, 8'h06);
    rdr(CCU_OFS_FLAG);
    check("aux status select", rd & 16'h0014, 16'h0014);
    window(320);
    cnt("aux source", n_sys, n_aux);
    pulse(0);
    window(1280);
    cnt("aux div16", n_sys, n_aux / 16);
    pulse(3);
    wr(CCU_OFS_CTL, 8'h00);
    wr(CCU_OFS_FLAG, 8'h02);
    aux_on <= 1'b0;
    $display("test wait done");
  endtask
  task automatic t_pll();
    int tries;
    for (int m = 0; m < 4; m++) begin
      wr(CCU_OFS_PLL, 8'h10 | m[7:0]);
      rdr(CCU_OFS_PLL);
      check("pll multiply field", rd, 16'h0010 | m[15:0]);
    end
    wr(CCU_OFS_PLL, 8'h10);
    tries = 0;
    rdr(CCU_OFS_FLAG);
    while (rd[3] !== 1'b1 && tries < 400) begin
      tries++;
      rdr(CCU_OFS_FLAG);
    end
    check("pll locks", rd & 16'h0008, 16'h0008);
    wr(CCU_OFS_FLAG, 8'h03);
    window(800);
    cnt("post div by 2", n_fast, 2 * n_sys);
    check("fast exported", n_fast > 0, 1'b1);
    // Halved reference leaves room for six fast ticks per reference period
    wr(CCU_OFS_MODE, 8'h20);
    wr(CCU_OFS_PLL, 8'h21);
    window(800);
    cnt("multiply by 6", n_fast / 6, n_ref);
    cnt("post div by 3", n_fast / 3, n_sys);
    wr(CCU_OFS_MODE, 8'h00);
    wr(CCU_OFS_PLL, 8'h70);
    rdr(CCU_OFS_FLAG);
    check("pll off no lock", rd & 16'h0008, 16'h0000);
    window(400);
    cnt("back to ref", n_sys, n_ref);
    wr(CCU_OFS_FLAG, 8'h02);
    $display("test pll done");
  endtask
  task automatic t_power();
    int b;
    pulse(1);
    check("halt ignored", halted, 1'b0);
    pulse(2);
    check("stop entered", {stopped, osc_enable}, 2'b10);
    window(60);
    check("stop frozen", n_sys[15:0], 16'h0000);
    pulse(3);
    check("stop left", {stopped, osc_enable}, 2'b01);
    wr(CCU_OFS_CTL, 8'h08);
    pulse(1);
    check("halt entered", {halted, osc_enable}, 2'b10);
    window(100);
    check("halt frozen", n_sys[15:0], 16'h0000);
    pulse(3);
    check("halt kept", halted, 1'b1);
    do_reset();
    @(negedge clock);
    check("halt left", halted, 1'b0);
    // Soft, watchdog and hardware causes each flag and clear by writing one
    for (int k = 0; k < 3; k++) begin
      b = (k == 0) ? 6 : (k == 1) ? 5 : 7;
      pulse(4 + k);
      rdr(CCU_OFS_FLAG);
      check("cause set", rd[b], 1'b1);
      wr(CCU_OFS_FLAG, 8'h02 | (8'h01 << b));
      rdr(CCU_OFS_FLAG);
      check("cause cleared", rd[b], 1'b0);
    end
    $display("test power done");
  endtask

  initial begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    t_reset();
    t_clocks();
    t_wait();
    t_pll();
    t_power();
    end_sim();
  end
endmodule // ccu_clock_control_tb
`default_nettype wire

// file: test/ccu_osc_model.sv
// Partner model: crystal or pulse generator on the oscillator pin, optional aux clock
`timescale 1ns/1ps
`default_nettype none

module ccu_osc_model (
  input wire logic clock,
  input wire logic osc_enable,
  input wire logic aux_on,
  output logic osc_input_clock,
  output logic auxiliary_clock,
  output logic aux_present
);
  // ==========================================================================
  // Sources
  // ==========================================================================
  localparam int HALF = 2;
  localparam int AUX_PER = 8;
  int osc_cnt = 0;
  int aux_cnt = 0;
  initial osc_input_clock = 1'b0;
  initial auxiliary_clock = 1'b0;
  // Square wave; it freezes while the device holds the oscillator off
  always @(posedge clock) begin
    if (osc_enable === 1'b1) begin
      osc_cnt <= (osc_cnt == HALF - 1) ? 0 : osc_cnt + 1;
      if (osc_cnt == HALF - 1) begin
        osc_input_clock <= ~osc_input_clock;
      end
    end
  end
  // Aux edges as one-cycle marks; an absent source leaves a dead line
  always @(posedge clock) begin
    aux_cnt <= (aux_cnt == AUX_PER - 1) ? 0 : aux_cnt + 1;
    auxiliary_clock <= aux_on && (aux_cnt == 0);
  end
  assign aux_present = aux_on;
endmodule // ccu_osc_model
`default_nettype wire
